/* ivc_pkg.sv */
// constants, register map and request numbering of the interrupt vector controller
package ivc_pkg;

	localparam int NREQ = 41;
	localparam int REQ_W = 6;
	localparam int FLAGS_PER_REG = 16;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_STRIDE = 4;
	localparam int PRIO_W = 3;

	// byte offsets on the register bus
	localparam logic [11:0] OFS_FLAG = 12'h000;
	localparam logic [11:0] OFS_ENABLE = 12'h00c;
	localparam logic [11:0] OFS_PRIO = 12'h018;
	localparam logic [11:0] OFS_CTRL2 = 12'h044;
	localparam logic [11:0] OFS_ACTIVE = 12'h048;

	// control register two layout
	localparam int GIE_BIT = 15;
	localparam int TIMED_DISABLE_ACTIVE_BIT = 14;
	localparam int SOFTWARE_TRAP_BIT_BIT = 13;
	localparam int EP_LSB = 0;
	localparam logic [15:0] CTRL2_RST = 16'h8000;

	// priority thresholds: level 0 never interrupts, timed disable passes only level 7
	localparam logic [2:0] LVL_OFF = 3'h0;
	localparam logic [2:0] LVL_TIMED_DISABLE_ACTIVE = 3'h6;

	// vector table
	localparam logic [7:0] VEC_BASE = 8'h08;
	localparam logic [23:0] IVT_BASE = 24'h00_0014;
	localparam logic [23:0] IVT_STEP = 24'h00_0002;
	localparam logic [23:0] RESET_ADDR = 24'h00_0000;

	// request numbers per source
	localparam logic [REQ_W-1:0] EXT_REQ [3] = '{6'h00, 6'h14, 6'h1d};
	localparam logic [REQ_W-1:0] SERIAL_REQ [4] = '{6'h0b, 6'h0c, 6'h1e, 6'h1f};
	localparam logic [REQ_W-1:0] DMA_REQ [4] = '{6'h04, 6'h0e, 6'h18, 6'h24};
	localparam logic [REQ_W-1:0] CAPTURE_REQ [8] = '{6'h01, 6'h05, 6'h25, 6'h26, 6'h27, 6'h28, 6'h16, 6'h17};
	localparam logic [REQ_W-1:0] COMPARE_REQ [4] = '{6'h02, 6'h06, 6'h19, 6'h1a};
	localparam logic [REQ_W-1:0] SYNC_REQ [4] = '{6'h09, 6'h0a, 6'h20, 6'h21};
	localparam logic [REQ_W-1:0] TIMER_REQ [5] = '{6'h03, 6'h07, 6'h08, 6'h1b, 6'h1c};
	localparam logic [REQ_W-1:0] CONV_REQ [2] = '{6'h0d, 6'h15};
	localparam logic [REQ_W-1:0] I2C_REQ [2] = '{6'h10, 6'h11};
	localparam logic [REQ_W-1:0] CAN_REQ [2] = '{6'h22, 6'h23};
	localparam logic [REQ_W-1:0] REQ_COMPARATOR = 6'h12;
	localparam logic [REQ_W-1:0] REQ_INPUT_CHANGE = 6'h13;
	localparam logic [REQ_W-1:0] REQ_RESERVED = 6'h0f;

	// variant option: can controller fitted
	localparam logic CAN_FITTED = 1'b1;
	localparam logic [NREQ-1:0] IMPL_ALL = 41'h1ff_ffff_7fff;
	localparam logic [NREQ-1:0] CAN_BITS = 41'h00c_0000_0000;
	localparam logic [NREQ-1:0] IMPL_MASK = CAN_FITTED ? IMPL_ALL : (IMPL_ALL & ~CAN_BITS);

endpackage : ivc_pkg

/* ivc_pin_edge.sv */
// external interrupt pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module ivc_pin_edge (
	// clock
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// pin and polarity
	input wire logic pin,
	input wire logic falling,
	// detected edge
	output logic hit
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else if (ce) begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// only the second and third stages are compared, never the metastable one
	assign hit = falling ? (last_r & ~sync_r) : (sync_r & ~last_r);

endmodule : ivc_pin_edge

/* ivc_vector_control.sv */
// interrupt vector controller: request flags, enables, priorities, control two and arbitration
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module ivc_vector_control import ivc_pkg::*; (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external interrupt pins
	input wire logic [2:0] ext_pin,
	// peripheral requests, same clock
	input wire logic [3:0] serial_req,
	input wire logic [3:0] sync_serial_req,
	input wire logic [3:0] dma_req,
	input wire logic [7:0] capture_req,
	input wire logic [3:0] compare_req,
	input wire logic [4:0] timer_req,
	input wire logic [1:0] converter_req,
	input wire logic [1:0] i2c_req,
	input wire logic comparator_event_req,
	input wire logic input_change_req,
	input wire logic [1:0] can_req,
	// processor core
	input wire logic core_timed_disable,
	output logic cpu_irq,
	output logic [7:0] cpu_irq_vector,
	output logic [2:0] cpu_irq_level,
	output logic [23:0] cpu_irq_addr,
	output logic core_trap_req,
	output logic core_restart,
	output logic [23:0] core_restart_addr
);

	logic [NREQ-1:0] flag_r;
	logic [NREQ-1:0] flag_nxt;
	logic [NREQ-1:0] enable_r;
	logic [NREQ-1:0] set_vec;
	logic [NREQ-1:0] elig_vec;
	logic [PRIO_W-1:0] prio_r [NREQ];
	logic global_irq_enable_r;
	logic timed_disable_active_r;
	logic software_trap_bit_r;
	logic [2:0] ext_pol_r;
	logic [2:0] ext_hit;
	logic restart_r;
	logic cpu_irq_r;
	logic [7:0] cpu_irq_vector_r;
	logic [2:0] cpu_irq_level_r;
	logic [23:0] cpu_irq_addr_r;
	logic [REQ_W-1:0] cpu_irq_req_r;
	logic [31:0] prdata_r;
	logic [11:0] rel;
	logic [3:0] idx;
	logic is_flag;
	logic is_en;
	logic is_prio;
	logic is_ctrl;
	logic is_act;
	logic hit;
	logic [15:0] rd16;
	logic [15:0] wd16;
	logic [47:0] flag_pad;
	logic [47:0] en_pad;
	logic wr_go;
	logic found;
	logic [2:0] best_lvl;
	logic [REQ_W-1:0] best_n;
	logic [2:0] thr;
	logic irq_nxt;
	logic rd16_timed_disable_active_ok;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// reset restart, kept apart from arbitration

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_r <= 1'b1;
		end else if (ce) begin
			restart_r <= 1'b0;
		end
	end

	assign core_restart = restart_r;
	assign core_restart_addr = RESET_ADDR;

	property p_restart_once;
		core_restart && ce |=> !core_restart;
	endproperty
	a_restart_once: assert property (p_restart_once) else $error("restart not released");

	property p_restart_no_irq;
		core_restart |-> !cpu_irq;
	endproperty
	a_restart_no_irq: assert property (p_restart_no_irq) else $error("irq during restart");

	////////////////////////////////////////////////////////////////////////////////
	// apb decode and read mux

	always_comb begin
		rel = 12'h000;
		is_flag = 1'b0;
		is_en = 1'b0;
		is_prio = 1'b0;
		is_ctrl = 1'b0;
		is_act = 1'b0;
		if (paddr < OFS_ENABLE) begin
			rel = paddr - OFS_FLAG;
			is_flag = 1'b1;
		end else if (paddr < OFS_PRIO) begin
			rel = paddr - OFS_ENABLE;
			is_en = 1'b1;
		end else if (paddr < OFS_CTRL2) begin
			rel = paddr - OFS_PRIO;
			is_prio = 1'b1;
		end else if (paddr[11:2] == OFS_CTRL2[11:2]) begin
			is_ctrl = 1'b1;
		end else if (paddr[11:2] == OFS_ACTIVE[11:2]) begin
			is_act = 1'b1;
		end
	end

	assign idx = rel[5:2];
	assign hit = is_flag | is_en | is_prio | is_ctrl | is_act;
	assign flag_pad = {7'h00, flag_r};
	assign en_pad = {7'h00, enable_r};

	always_comb begin
		rd16 = 16'h0000;
		if (is_flag) begin
			rd16 = flag_pad[int'(idx) * FLAGS_PER_REG +: FLAGS_PER_REG];
		end else if (is_en) begin
			rd16 = en_pad[int'(idx) * FLAGS_PER_REG +: FLAGS_PER_REG];
		end else if (is_prio) begin
			for (int i = 0; i < FIELDS_PER_REG; i++) begin
				if (int'(idx) * FIELDS_PER_REG + i < NREQ) begin
					rd16[i * FIELD_STRIDE +: PRIO_W] = prio_r[int'(idx) * FIELDS_PER_REG + i];
				end
			end
		end else if (is_ctrl) begin
			rd16[GIE_BIT] = global_irq_enable_r;
			rd16[TIMED_DISABLE_ACTIVE_BIT] = timed_disable_active_r;
			rd16[SOFTWARE_TRAP_BIT_BIT] = software_trap_bit_r;
			rd16[EP_LSB +: 3] = ext_pol_r;
		end else if (is_act) begin
			rd16 = {cpu_irq_r, 4'h0, cpu_irq_level_r, cpu_irq_vector_r};
		end
	end

	// lanes not strobed keep the stored byte
	assign wd16 = {pstrb[1] ? pwdata[15:8] : rd16[15:8], pstrb[0] ? pwdata[7:0] : rd16[7:0]};
	assign wr_go = psel & penable & pwrite & ce & hit;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			prdata_r <= {16'h0000, rd16};
		end
	end

	assign prdata = prdata_r;
	assign pready = ce;
	assign pslverr = psel & penable & ~hit;

	property p_ctrl_zero;
		ce && psel && !penable && is_ctrl |=> prdata[12:3] == 10'h000;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("unimplemented control bits not zero");

	////////////////////////////////////////////////////////////////////////////////
	// control register two

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_enable_r <= CTRL2_RST[GIE_BIT];
			timed_disable_active_r <= CTRL2_RST[TIMED_DISABLE_ACTIVE_BIT];
			software_trap_bit_r <= CTRL2_RST[SOFTWARE_TRAP_BIT_BIT];
			ext_pol_r <= CTRL2_RST[EP_LSB +: 3];
		end else if (ce) begin
			if (wr_go && is_ctrl) begin
				global_irq_enable_r <= wd16[GIE_BIT];
				timed_disable_active_r <= wd16[TIMED_DISABLE_ACTIVE_BIT];
				software_trap_bit_r <= wd16[SOFTWARE_TRAP_BIT_BIT];
				ext_pol_r <= wd16[EP_LSB +: 3];
			end else begin
				timed_disable_active_r <= core_timed_disable;
			end
		end
	end

	// trap path ignores the global enable
	assign core_trap_req = software_trap_bit_r;

	property p_trap;
		wr_go && is_ctrl && wd16[SOFTWARE_TRAP_BIT_BIT] |=> core_trap_req;
	endproperty
	a_trap: assert property (p_trap) else $error("software trap not raised");

	property p_timed_disable_active;
		ce && core_timed_disable && !(wr_go && is_ctrl) |=> rd16_timed_disable_active_ok;
	endproperty
	assign rd16_timed_disable_active_ok = timed_disable_active_r;
	a_timed_disable_active: assert property (p_timed_disable_active) else $error("timed disable status missing");

	////////////////////////////////////////////////////////////////////////////////
	// request sources

	for (genvar g = 0; g < 3; g++) begin : g_ext
		ivc_pin_edge u_edge (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.pin(ext_pin[g]),
			.falling(ext_pol_r[g]),
			.hit(ext_hit[g])
		);
	end

	always_comb begin
		set_vec = '0;
		for (int i = 0; i < 3; i++) set_vec[EXT_REQ[i]] = ext_hit[i];
		for (int i = 0; i < 4; i++) begin
			set_vec[SERIAL_REQ[i]] = serial_req[i];
			set_vec[DMA_REQ[i]] = dma_req[i];
			set_vec[COMPARE_REQ[i]] = compare_req[i];
			set_vec[SYNC_REQ[i]] = sync_serial_req[i];
		end
		for (int i = 0; i < 8; i++) set_vec[CAPTURE_REQ[i]] = capture_req[i];
		for (int i = 0; i < 5; i++) set_vec[TIMER_REQ[i]] = timer_req[i];
		for (int i = 0; i < 2; i++) begin
			set_vec[CONV_REQ[i]] = converter_req[i];
			set_vec[I2C_REQ[i]] = i2c_req[i];
			set_vec[CAN_REQ[i]] = can_req[i] & CAN_FITTED;
		end
		set_vec[REQ_COMPARATOR] = comparator_event_req;
		set_vec[REQ_INPUT_CHANGE] = input_change_req;
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags, enables, priorities

	// a hardware set in the same cycle as a software clear wins
	always_comb begin
		for (int n = 0; n < NREQ; n++) begin
			flag_nxt[n] = ((wr_go && is_flag && int'(idx) == n / FLAGS_PER_REG) ? wd16[n % FLAGS_PER_REG] : flag_r[n])
				| set_vec[n];
		end
		flag_nxt = flag_nxt & IMPL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= '0;
		end else if (ce) begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= '0;
		end else if (ce && wr_go && is_en) begin
			for (int n = 0; n < NREQ; n++) begin
				if (int'(idx) == n / FLAGS_PER_REG) enable_r[n] <= wd16[n % FLAGS_PER_REG] & IMPL_MASK[n];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int n = 0; n < NREQ; n++) prio_r[n] <= LVL_OFF;
		end else if (ce && wr_go && is_prio) begin
			for (int n = 0; n < NREQ; n++) begin
				if (int'(idx) == n / FIELDS_PER_REG && IMPL_MASK[n]) begin
					prio_r[n] <= wd16[(n % FIELDS_PER_REG) * FIELD_STRIDE +: PRIO_W];
				end
			end
		end
	end

	property p_reserved;
		!flag_r[REQ_RESERVED] && !(cpu_irq && cpu_irq_req_r == REQ_RESERVED);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved request raised");

	sequence s_ext0_rise;
		$rose(ext_pin[0]) && !ext_pol_r[0] && ce ##1 ce [*2];
	endsequence
	property p_ext0_rise;
		s_ext0_rise |=> flag_r[EXT_REQ[0]];
	endproperty
	a_ext0_rise: assert property (p_ext0_rise) else $error("rising edge on pin 0 lost");

	sequence s_ext1_fall;
		$fell(ext_pin[1]) && ext_pol_r[1] && ce ##1 ce [*2];
	endsequence
	property p_ext1_fall;
		s_ext1_fall |=> flag_r[EXT_REQ[1]];
	endproperty
	a_ext1_fall: assert property (p_ext1_fall) else $error("falling edge on pin 1 lost");

	////////////////////////////////////////////////////////////////////////////////
	// arbitration: highest level, ties go to the lowest request number

	assign elig_vec = flag_r & enable_r & IMPL_MASK;
	// timed disable holds off everything below the top level
	assign thr = timed_disable_active_r ? LVL_TIMED_DISABLE_ACTIVE : LVL_OFF;

	always_comb begin
		found = 1'b0;
		best_lvl = LVL_OFF;
		best_n = '0;
		for (int n = 0; n < NREQ; n++) begin
			if (elig_vec[n] && prio_r[n] > thr && (!found || prio_r[n] > best_lvl)) begin
				found = 1'b1;
				best_lvl = prio_r[n];
				best_n = REQ_W'(n);
			end
		end
	end

	assign irq_nxt = found & global_irq_enable_r & ~restart_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_irq_r <= 1'b0;
			cpu_irq_vector_r <= 8'h00;
			cpu_irq_level_r <= LVL_OFF;
			cpu_irq_addr_r <= 24'h00_0000;
			cpu_irq_req_r <= '0;
		end else if (ce) begin
			cpu_irq_r <= irq_nxt;
			cpu_irq_vector_r <= VEC_BASE + 8'(best_n);
			cpu_irq_level_r <= best_lvl;
			cpu_irq_addr_r <= IVT_BASE + 24'(best_n) * IVT_STEP;
			cpu_irq_req_r <= best_n;
		end
	end

	assign cpu_irq = cpu_irq_r;
	assign cpu_irq_vector = cpu_irq_vector_r;
	assign cpu_irq_level = cpu_irq_level_r;
	assign cpu_irq_addr = cpu_irq_addr_r;

	property p_vec_addr;
		cpu_irq |-> cpu_irq_addr == IVT_BASE + 24'(cpu_irq_vector - VEC_BASE) * IVT_STEP;
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("table address mismatch");

	property p_merge;
		ce && found && global_irq_enable_r && !restart_r |=> cpu_irq && cpu_irq_level == $past(best_lvl);
	endproperty
	a_merge: assert property (p_merge) else $error("pending request not forwarded");

	property p_gie_block;
		ce && !global_irq_enable_r |=> !cpu_irq;
	endproperty
	a_gie_block: assert property (p_gie_block) else $error("irq with global enable off");

	property p_lowest_wins;
		ce && irq_nxt && elig_vec[0] && prio_r[0] == best_lvl |=> cpu_irq_vector == VEC_BASE;
	endproperty
	a_lowest_wins: assert property (p_lowest_wins) else $error("tie not given to lowest vector");

endmodule : ivc_vector_control

/* ivc_far_end.sv */
// far-end model: peripheral request sources and the core's timed disable level
`timescale 1ns/1ps
module ivc_far_end (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// commands from the bench
	input wire logic go,
	input wire logic [5:0] idx,
	input wire logic td_cmd,
	// towards the controller
	output logic [36:0] src,
	output logic core_timed_disable
);
	// request lines get one-cycle pulses only, timed disable is a level: a held request would hide a flag that fails to latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src <= '0;
			core_timed_disable <= 1'b0;
		end else begin
			src <= go ? (37'h0_0000_0001 << idx) : '0;
			core_timed_disable <= td_cmd;
		end
	end
endmodule : ivc_far_end

/* ivc_vector_control_tb.sv */
// self-checking bench of the interrupt vector controller against a behavioural model
`timescale 1ns/1ps
module ivc_vector_control_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic go = 1'b0;
	logic td_cmd = 1'b0;
	logic ce = 1'b1;
	logic [3:0] strb = 4'hf;
	logic err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [2:0] ext_pin = '0;
	logic [5:0] idx = '0;
	logic [31:0] prdata;
	logic pready, pslverr, cpu_irq, core_trap_req, core_restart, core_timed_disable;
	logic [7:0] vec;
	logic [2:0] lvl;
	logic [23:0] addr, rst_addr;
	logic [36:0] src;
	logic [31:0] rng = 32'ha5c1;
	int n_mismatch = 0;
	int checks_done = 0;
	bit mflag[41];
	bit men[41];
	int mprio[41];
	// request number of each source line, in src bit order
	int exp_req[37] = '{11, 12, 30, 31, 9, 10, 32, 33, 4, 14, 24, 36, 1, 5, 37, 38, 39, 40, 22, 23,
		2, 6, 25, 26, 3, 7, 8, 27, 28, 13, 21, 16, 17, 18, 19, 34, 35};
	int ext_req[3] = '{0, 20, 29};

	ivc_vector_control DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin(ext_pin), .serial_req(src[3:0]), .sync_serial_req(src[7:4]),
		.dma_req(src[11:8]), .capture_req(src[19:12]), .compare_req(src[23:20]), .timer_req(src[28:24]),
		.converter_req(src[30:29]), .i2c_req(src[32:31]), .comparator_event_req(src[33]),
		.input_change_req(src[34]), .can_req(src[36:35]), .core_timed_disable(core_timed_disable),
		.cpu_irq(cpu_irq), .cpu_irq_vector(vec), .cpu_irq_level(lvl), .cpu_irq_addr(addr),
		.core_trap_req(core_trap_req), .core_restart(core_restart), .core_restart_addr(rst_addr));

	ivc_far_end far (.pclk(pclk), .presetn(presetn), .go(go), .idx(idx), .td_cmd(td_cmd), .src(src),
		.core_timed_disable(core_timed_disable));

	initial begin
		forever #5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// entered just after a rising edge; idle cycle at the end keeps strobes single-driven
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 16'h0000, r);
		chk(nm, r, exp);
	endtask : rd

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs

	// strict greater keeps the lowest request number on a tie
	function automatic int winner(input int thr);
		int b;
		b = -1;
		for (int n = 0; n < 41; n++)
			if (mflag[n] && men[n] && mprio[n] > thr && (b < 0 || mprio[n] > mprio[b]))
				b = n;
		return b;
	endfunction : winner

	task automatic sync_regs();
		logic [15:0] f, e, p;
		for (int m = 0; m < 11; m++) begin
			p = '0;
			for (int i = 0; i < 4; i++)
				if (4 * m + i < 41)
					p[4 * i +: 3] = 3'(mprio[4 * m + i]);
			wr(12'(24 + 4 * m), p);
		end
		for (int r = 0; r < 3; r++) begin
			f = '0;
			e = '0;
			for (int b = 0; b < 16; b++)
				if (16 * r + b < 41) begin
					f[b] = mflag[16 * r + b];
					e[b] = men[16 * r + b];
				end
			wr(12'(12 + 4 * r), e);
			wr(12'(4 * r), f);
		end
	endtask : sync_regs

	////////////////////////////////////////////////////////////
	initial begin
		// about 2000 cycles of tests; twice that leaves room without hiding a hang
		repeat (4000) @(posedge pclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("restart", core_restart, 1'b0);
		chk("restart_addr", rst_addr, 32'h0000_0000);
		rd("ctrl2", 12'h044, 32'h0000_8000);
		wr(12'h044, 16'hffff);
		rd("ctrl2_all", 12'h044, 32'h0000_a007);
		chk("trap", core_trap_req, 1'b1);
		rd("unmapped", 12'h100, 32'h0000_0000);
		chk("slverr", err, 1'b1);
		wr(12'h000, 16'hffff);
		rd("flag0", 12'h000, 32'h0000_7fff);
		wr(12'h00c, 16'hffff);
		rd("enable0", 12'h00c, 32'h0000_7fff);
		wr(12'h00c, 16'h0000);
		wr(12'h000, 16'h0000);
		$display("end registers");
		for (int i = 0; i < 37; i++) begin
			go <= 1'b1;
			idx <= 6'(i);
			@(posedge pclk);
			go <= 1'b0;
			repeat (2) @(posedge pclk);
			rd("map", 12'(4 * (exp_req[i] / 16)), 32'(1) << (exp_req[i] % 16));
			wr(12'(4 * (exp_req[i] / 16)), 16'h0000);
		end
		$display("end source map");
		// a request pulse while the clock enable is low must be lost
		ce <= 1'b0;
		go <= 1'b1;
		idx <= 6'd0;
		@(posedge pclk);
		go <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		rd("ce_freeze", 12'h000, 32'h0000_0000);
		// low byte only: polarity bits cleared, high byte kept
		strb <= 4'h1;
		wr(12'h044, 16'h0000);
		strb <= 4'hf;
		rd("ctrl2_strb", 12'h044, 32'h0000_a000);
		$display("end enable and strobes");
		for (int k = 0; k < 3; k++)
			for (int pol = 0; pol < 2; pol++) begin
				wr(12'h044, 16'(16'h8000 | (pol << k)));
				for (int s = 1; s >= 0; s--) begin
					wr(12'(4 * (ext_req[k] / 16)), 16'h0000);
					ext_pin[k] <= s[0];
					repeat (6) @(posedge pclk);
					rd("pin", 12'(4 * (ext_req[k] / 16)), 32'(s ^ pol) << (ext_req[k] % 16));
				end
			end
		$display("end pins");
		for (int t = 0; t < 24; t++) begin
			logic [31:0] c;
			logic global_irq_enable, td, sw;
			int w;
			for (int n = 0; n < 41; n++) begin
				mflag[n] = (xs() % 6 == 0) && n != 15;
				men[n] = xs() % 3 != 0;
				mprio[n] = xs() % 8;
			end
			c = xs();
			global_irq_enable = c[2:1] != 2'b00;
			td = c[0];
			sw = c[3];
			td_cmd <= td;
			sync_regs();
			wr(12'h044, {global_irq_enable, 1'b0, sw, 13'h0000});
			repeat (3) @(posedge pclk);
			w = global_irq_enable ? winner(td ? 6 : 0) : -1;
			chk("irq", cpu_irq, w >= 0);
			if (w >= 0) begin
				chk("vector", vec, 32'(8 + w));
				chk("table_addr", addr, 32'(20 + 2 * w));
				chk("level", lvl, 32'(mprio[w]));
			end
			chk("trap_out", core_trap_req, sw);
			rd("ctrl2_st", 12'h044, {16'h0000, global_irq_enable, td, sw, 13'h0000});
		end
		$display("end arbitration");
		presetn <= 1'b0;
		td_cmd <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("restart_rst", core_restart, 1'b1);
		chk("irq_rst", cpu_irq, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd("ctrl2_rst", 12'h044, 32'h0000_8000);
		$display("end second reset");
		wrap_up();
	end
endmodule : ivc_vector_control_tb
